//--- hdl/iocr_clk_if.sv
// Clock-output selection carried from the register file to the clock mux
`timescale 1ns/10ps
`default_nettype none
interface iocr_clk_if;
   logic [1:0] sel;
   logic lf_off;
   logic xtal_run;
   logic div_tick;
   logic lf_clk;
   logic clk_out;
   modport ctl (output sel, output lf_off, output xtal_run, output div_tick,
      output lf_clk, input clk_out);
   modport mux (input sel, input lf_off, input xtal_run, input div_tick,
      input lf_clk, output clk_out);
endinterface
`default_nettype wire

//--- hdl/iocr_clk_mux.sv
// Host clock output divider and source select
`timescale 1ns/10ps
`default_nettype none
module iocr_clk_mux
   import iocr_pkg::*;
(
   input wire logic MCLK_I,
   input wire logic RST_I,
   iocr_clk_if.mux cif
);
   logic [1:0] div_r;
   logic [1:0] div_nxt;
   logic out_r;
   logic out_nxt;

   always_comb begin
      div_nxt = div_r;
      if (cif.div_tick) begin
         div_nxt = 2'(div_r + 2'h1);
      end
   end

   always_comb begin
      out_nxt = 1'b0;
      if (cif.xtal_run) begin
         case (cif.sel)
            CLK_DIV4: out_nxt = div_nxt[1];
            CLK_DIV2: out_nxt = div_nxt[0];
            CLK_DIV1: out_nxt = cif.div_tick;
            default: out_nxt = 1'b0;
         endcase
      end else if (cif.sel != CLK_OFF && !cif.lf_off) begin
         out_nxt = cif.lf_clk;
      end
   end

   always_ff @(posedge MCLK_I) begin
      if (RST_I) begin
         div_r <= 2'h0;
         out_r <= 1'b0;
      end else begin
         div_r <= div_nxt;
         out_r <= out_nxt;
      end
   end

   assign cif.clk_out = out_r;

   property p_off_low;
      @(posedge MCLK_I) disable iff (RST_I)
      (cif.sel == CLK_OFF) |=> !out_r;
   endproperty
   a_off_low: assert property (p_off_low) else $error("clock out not low when off");

   property p_lf_gate;
      @(posedge MCLK_I) disable iff (RST_I)
      (!cif.xtal_run && cif.lf_off) |=> !out_r;
   endproperty
   a_lf_gate: assert property (p_lf_gate) else $error("lf clock not gated");
endmodule
`default_nettype wire

//--- hdl/iocr_pkg.sv
// Constants for the IO configuration register pair
package iocr_pkg;
   localparam logic [7:0] ADDR_CFG_A = 8'h00;
   localparam logic [7:0] ADDR_CFG_B = 8'h01;
   // First register fields
   localparam int BIT_SINGLE = 7;
   localparam int BIT_DRV_SEL = 6;
   localparam int BIT_RX_LVL = 5;
   localparam int BIT_TX_LVL = 4;
   localparam int BIT_XTAL = 3;
   localparam int BIT_CLK_HI = 2;
   localparam int BIT_CLK_LO = 1;
   localparam int BIT_LF_OFF = 0;
   // Second register fields
   localparam int BIT_SUPPLY = 7;
   localparam int BIT_REG_OFF = 6;
   localparam int BIT_PD_SEL = 4;
   localparam int BIT_PD_DESEL = 3;
   localparam int BIT_IO18 = 2;
   localparam int BIT_SLOW = 0;
   localparam logic [7:0] CFG_B_MASK = 8'hdd;
   localparam logic [7:0] CFG_A_RST = 8'h08;
   localparam logic [7:0] CFG_B_RST = 8'h00;
   localparam logic [6:0] RX_LVL_LO = 7'h40;
   localparam logic [6:0] RX_LVL_HI = 7'h50;
   localparam logic [6:0] TX_LVL_LO = 7'h20;
   localparam logic [6:0] TX_LVL_HI = 7'h10;
   // Clock-out select codes: crystal clock divided by 4, 2 or 1, or off (13.56 MHz base)
   localparam logic [1:0] CLK_DIV4 = 2'h0;
   localparam logic [1:0] CLK_DIV2 = 2'h1;
   localparam logic [1:0] CLK_DIV1 = 2'h2;
   localparam logic [1:0] CLK_OFF = 2'h3;
   // Slow ramp: least 10 us, rounded up at 40 MHz
   localparam int RAMP_NS = 10000;
   localparam int CLK_NS = 25;
   localparam int RAMP_CYC = (RAMP_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [8:0] RAMP_LAST = 9'(RAMP_CYC - 1);
   typedef enum logic [1:0] {
      RMP_IDLE = 2'b00,
      RMP_RUN = 2'b01,
      RMP_ON = 2'b11
   } iocr_ramp_t;
endpackage

//--- hdl/iocr_regs.sv
// IO configuration register pair and the controls it steers
`timescale 1ns/10ps
`default_nettype none
module iocr_regs
   import iocr_pkg::*;
(
   input wire logic MCLK_I,
   input wire logic RST_I,
   input wire logic POR_I,
   input wire logic WR_I,
   input wire logic RD_I,
   input wire logic [7:0] ADDR_I,
   input wire logic [7:0] WDATA_I,
   output logic [7:0] RDATA_O,
   input wire logic XTAL_RUN_I,
   input wire logic XTAL_TICK_I,
   input wire logic LF_CLK_I,
   input wire logic SS_N_I,
   input wire logic SDO_DRIVE_I,
   input wire logic TX_ON_I,
   output logic SINGLE_ENDED_O,
   output logic ANTENNA_OUT_A_EN_O,
   output logic ANTENNA_OUT_B_EN_O,
   output logic ANTENNA_IN_A_EN_O,
   output logic ANTENNA_IN_B_EN_O,
   output logic [6:0] RX_WATER_LEVEL_O,
   output logic [6:0] TX_WATER_LEVEL_O,
   output logic CRYSTAL_FREQ_SEL_O,
   output logic MCU_CLK_O,
   output logic SUPPLY_MODE_SEL_O,
   output logic DIGITAL_SUPPLY_NODE_OFF_O,
   output logic SDO_PULLDOWN_EN_O,
   output logic SDO_HIGH_DRIVE_O,
   output logic TX_RAMP_SLOW_O,
   output logic TX_RAMP_DONE_O
);
   logic [7:0] cfg_a_r;
   logic [7:0] cfg_a_nxt;
   logic [7:0] cfg_b_r;
   logic [7:0] cfg_b_nxt;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   iocr_ramp_t ramp_r;
   iocr_ramp_t ramp_nxt;
   logic [8:0] ramp_cnt_r;
   logic [8:0] ramp_cnt_nxt;
   logic [6:0] rx_lvl_r;
   logic [6:0] tx_lvl_r;
   logic pd_r;
   logic pd_nxt;

   iocr_clk_if cif ();

   // Register storage: power-up only
   always_comb begin
      cfg_a_nxt = cfg_a_r;
      cfg_b_nxt = cfg_b_r;
      rdata_nxt = rdata_r;
      if (WR_I && ADDR_I == ADDR_CFG_A) begin
         cfg_a_nxt = WDATA_I;
      end
      if (WR_I && ADDR_I == ADDR_CFG_B) begin
         cfg_b_nxt = WDATA_I & CFG_B_MASK;
      end
      if (RD_I) begin
         case (ADDR_I)
            ADDR_CFG_A: rdata_nxt = cfg_a_r;
            ADDR_CFG_B: rdata_nxt = cfg_b_r;
            default: rdata_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge MCLK_I) begin
      if (POR_I) begin
         cfg_a_r <= CFG_A_RST;
         cfg_b_r <= CFG_B_RST;
      end else begin
         cfg_a_r <= cfg_a_nxt;
         cfg_b_r <= cfg_b_nxt;
      end
   end

   // Read data follows ordinary reset
   always_ff @(posedge MCLK_I) begin
      if (RST_I || POR_I) begin
         rdata_r <= 8'h00;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end
   assign RDATA_O = rdata_r;

   // Derived controls, registered so data outputs come from flops
   logic single_r;
   logic out_a_r;
   logic out_b_r;
   logic xtal_r;
   logic sup_r;
   logic reg_off_r;
   logic io18_r;
   always_ff @(posedge MCLK_I) begin
      if (POR_I) begin
         single_r <= 1'b0;
         out_a_r <= 1'b1;
         out_b_r <= 1'b1;
         rx_lvl_r <= RX_LVL_LO;
         tx_lvl_r <= TX_LVL_LO;
         xtal_r <= 1'b1;
         sup_r <= 1'b0;
         reg_off_r <= 1'b0;
         io18_r <= 1'b0;
      end else begin
         single_r <= cfg_a_r[BIT_SINGLE];
         out_a_r <= !cfg_a_r[BIT_SINGLE] || !cfg_a_r[BIT_DRV_SEL];
         out_b_r <= !cfg_a_r[BIT_SINGLE] || cfg_a_r[BIT_DRV_SEL];
         rx_lvl_r <= cfg_a_r[BIT_RX_LVL] ? RX_LVL_HI : RX_LVL_LO;
         tx_lvl_r <= cfg_a_r[BIT_TX_LVL] ? TX_LVL_HI : TX_LVL_LO;
         xtal_r <= cfg_a_r[BIT_XTAL];
         sup_r <= cfg_b_r[BIT_SUPPLY];
         reg_off_r <= cfg_b_r[BIT_REG_OFF];
         io18_r <= cfg_b_r[BIT_IO18];
      end
   end
   assign SINGLE_ENDED_O = single_r;
   assign ANTENNA_OUT_A_EN_O = out_a_r;
   assign ANTENNA_OUT_B_EN_O = out_b_r;
   assign ANTENNA_IN_A_EN_O = out_a_r;
   assign ANTENNA_IN_B_EN_O = out_b_r;
   assign RX_WATER_LEVEL_O = rx_lvl_r;
   assign TX_WATER_LEVEL_O = tx_lvl_r;
   assign CRYSTAL_FREQ_SEL_O = xtal_r;
   assign SUPPLY_MODE_SEL_O = sup_r;
   assign DIGITAL_SUPPLY_NODE_OFF_O = reg_off_r;
   assign SDO_HIGH_DRIVE_O = io18_r;

   // Pull-down on the serial data output
   always_comb begin
      pd_nxt = 1'b0;
      if (!SS_N_I && !SDO_DRIVE_I && cfg_b_r[BIT_PD_SEL]) begin
         pd_nxt = 1'b1;
      end
      if (SS_N_I && cfg_b_r[BIT_PD_DESEL]) begin
         pd_nxt = 1'b1;
      end
   end
   always_ff @(posedge MCLK_I) begin
      if (RST_I || POR_I) begin
         pd_r <= 1'b0;
      end else begin
         pd_r <= pd_nxt;
      end
   end
   assign SDO_PULLDOWN_EN_O = pd_r;

   // Transmitter ramp sequencer; a fast ramp completes in one cycle
   always_comb begin
      ramp_nxt = ramp_r;
      ramp_cnt_nxt = ramp_cnt_r;
      case (ramp_r)
         RMP_IDLE: begin
            ramp_cnt_nxt = 9'h000;
            if (TX_ON_I) begin
               ramp_nxt = cfg_b_r[BIT_SLOW] ? RMP_RUN : RMP_ON;
            end
         end
         RMP_RUN: begin
            ramp_cnt_nxt = 9'(ramp_cnt_r + 9'h001);
            if (!TX_ON_I) begin
               ramp_nxt = RMP_IDLE;
            end else if (ramp_cnt_r == RAMP_LAST) begin
               ramp_nxt = RMP_ON;
            end
         end
         RMP_ON: begin
            if (!TX_ON_I) begin
               ramp_nxt = RMP_IDLE;
            end
         end
         default: ramp_nxt = RMP_IDLE;
      endcase
   end
   always_ff @(posedge MCLK_I) begin
      if (RST_I || POR_I) begin
         ramp_r <= RMP_IDLE;
         ramp_cnt_r <= 9'h000;
      end else begin
         ramp_r <= ramp_nxt;
         ramp_cnt_r <= ramp_cnt_nxt;
      end
   end
   assign TX_RAMP_SLOW_O = (ramp_r == RMP_RUN);
   assign TX_RAMP_DONE_O = (ramp_r == RMP_ON);

   // Host clock output
   assign cif.sel = {cfg_a_r[BIT_CLK_HI], cfg_a_r[BIT_CLK_LO]};
   assign cif.lf_off = cfg_a_r[BIT_LF_OFF];
   assign cif.xtal_run = XTAL_RUN_I;
   assign cif.div_tick = XTAL_TICK_I;
   assign cif.lf_clk = LF_CLK_I;
   iocr_clk_mux u_clk (
      .MCLK_I(MCLK_I),
      .RST_I(RST_I || POR_I),
      .cif(cif.mux)
   );
   assign MCU_CLK_O = cif.clk_out;

   property p_keep_on_reset;
      @(posedge MCLK_I) (RST_I && !POR_I && !WR_I) |=>
      (cfg_a_r == $past(cfg_a_r) && cfg_b_r == $past(cfg_b_r));
   endproperty
   a_keep_on_reset: assert property (p_keep_on_reset) else $error("reset altered config");

   property p_por_default;
      @(posedge MCLK_I) POR_I |=> (cfg_a_r == CFG_A_RST && cfg_b_r == CFG_B_RST);
   endproperty
   a_por_default: assert property (p_por_default) else $error("power-up default wrong");

   property p_unused_zero;
      @(posedge MCLK_I) disable iff (POR_I) (cfg_b_r & ~CFG_B_MASK) == 8'h00;
   endproperty
   a_unused_zero: assert property (p_unused_zero) else $error("unused bits set");

   property p_pair;
      @(posedge MCLK_I) disable iff (POR_I)
      (cfg_a_r[BIT_SINGLE] && cfg_a_r[BIT_DRV_SEL]) |=> (!out_a_r && out_b_r);
   endproperty
   a_pair: assert property (p_pair) else $error("wrong pair in single mode");

   property p_diff;
      @(posedge MCLK_I) disable iff (POR_I) !cfg_a_r[BIT_SINGLE] |=> (out_a_r && out_b_r);
   endproperty
   a_diff: assert property (p_diff) else $error("differential not on both");

   property p_rx_lvl;
      @(posedge MCLK_I) disable iff (POR_I)
      cfg_a_r[BIT_RX_LVL] |=> (rx_lvl_r == RX_LVL_HI);
   endproperty
   a_rx_lvl: assert property (p_rx_lvl) else $error("rx level wrong");

   property p_tx_lvl;
      @(posedge MCLK_I) disable iff (POR_I)
      cfg_a_r[BIT_TX_LVL] |=> (tx_lvl_r == TX_LVL_HI);
   endproperty
   a_tx_lvl: assert property (p_tx_lvl) else $error("tx level wrong");

   property p_pd_desel;
      @(posedge MCLK_I) disable iff (RST_I || POR_I)
      (SS_N_I && cfg_b_r[BIT_PD_DESEL]) |=> pd_r;
   endproperty
   a_pd_desel: assert property (p_pd_desel) else $error("deselect pull-down missing");

   property p_pd_sel;
      @(posedge MCLK_I) disable iff (RST_I || POR_I)
      (!SS_N_I && SDO_DRIVE_I) |=> !pd_r;
   endproperty
   a_pd_sel: assert property (p_pd_sel) else $error("pull-down while driving");

   property p_ramp_len;
      @(posedge MCLK_I) disable iff (RST_I || POR_I)
      (ramp_r == RMP_RUN && ramp_cnt_r < RAMP_LAST) |=> (ramp_r != RMP_ON);
   endproperty
   a_ramp_len: assert property (p_ramp_len) else $error("slow ramp too short");

   property p_supply;
      @(posedge MCLK_I) disable iff (POR_I)
      $rose(cfg_b_r[BIT_SUPPLY]) |=> sup_r;
   endproperty
   a_supply: assert property (p_supply) else $error("supply mode not followed");

   c_slow_ramp: cover property (@(posedge MCLK_I) ramp_r == RMP_RUN ##1 ramp_r == RMP_ON);
   c_single_b: cover property (@(posedge MCLK_I) single_r && out_b_r);
   c_pd_sel: cover property (@(posedge MCLK_I) !SS_N_I && pd_r);
endmodule
`default_nettype wire

//--- verif/iocr_host.sv
// Host model issuing register writes and reads
`timescale 1ns/10ps
`default_nettype none
module iocr_host (
   input wire logic clk_i,
   input wire logic [7:0] rdata_i,
   output logic wr_o,
   output logic rd_o,
   output logic [7:0] addr_o,
   output logic [7:0] wdata_o
);
   initial begin
      wr_o = 1'b0;
      rd_o = 1'b0;
      addr_o = 8'h5a;
      wdata_o = 8'ha5;
   end

   // Released lines are inverted so stale values never look valid
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i) #1;
      addr_o = a;
      wdata_o = d;
      wr_o = 1'b1;
      @(posedge clk_i) #1;
      wr_o = 1'b0;
      addr_o = ~a;
      wdata_o = ~d;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_i) #1;
      addr_o = a;
      rd_o = 1'b1;
      @(posedge clk_i) #1;
      rd_o = 1'b0;
      addr_o = ~a;
      d = rdata_i;
   endtask
endmodule
`default_nettype wire

//--- verif/tb.sv
// Self-checking bench for the IO configuration register pair
`timescale 1ns/10ps
`default_nettype none
module tb;
   import iocr_pkg::*;
   logic clk, rst, por, xrun, lfclk, ss_n, sdo_drv, tx_on;
   logic xtick = 1'b0;
   logic wr, rd;
   logic [7:0] addr, wdata, rdata, v;
   logic se, oa, ob, ia, ib, xsel, mclk, sup, vreg, pd, hd, slow, done;
   logic [6:0] rxl, txl;
   int n_mismatch = 0;
   int n_tests = 0;
   int n;

   iocr_regs DUT (.MCLK_I(clk), .RST_I(rst), .POR_I(por), .WR_I(wr), .RD_I(rd),
      .ADDR_I(addr), .WDATA_I(wdata), .RDATA_O(rdata), .XTAL_RUN_I(xrun),
      .XTAL_TICK_I(xtick), .LF_CLK_I(lfclk), .SS_N_I(ss_n), .SDO_DRIVE_I(sdo_drv),
      .TX_ON_I(tx_on), .SINGLE_ENDED_O(se), .ANTENNA_OUT_A_EN_O(oa),
      .ANTENNA_OUT_B_EN_O(ob), .ANTENNA_IN_A_EN_O(ia), .ANTENNA_IN_B_EN_O(ib),
      .RX_WATER_LEVEL_O(rxl), .TX_WATER_LEVEL_O(txl), .CRYSTAL_FREQ_SEL_O(xsel),
      .MCU_CLK_O(mclk), .SUPPLY_MODE_SEL_O(sup), .DIGITAL_SUPPLY_NODE_OFF_O(vreg),
      .SDO_PULLDOWN_EN_O(pd), .SDO_HIGH_DRIVE_O(hd), .TX_RAMP_SLOW_O(slow),
      .TX_RAMP_DONE_O(done));
   iocr_host host (.clk_i(clk), .rdata_i(rdata), .wr_o(wr), .rd_o(rd), .addr_o(addr),
      .wdata_o(wdata));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // Crystal tick every other cycle, so clock-out periods are 8, 4, 2 cycles
   always @(posedge clk) xtick <= #1 ~xtick;

   task automatic results();
      $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic settle(input int c);
      repeat (c) @(posedge clk);
      #1;
   endtask

   task automatic cfg(input logic [7:0] a, input logic [7:0] d);
      host.wr(a, d);
      settle(2);
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      host.rd(a, v);
      chk(v, exp);
   endtask

   // Cycles between two rising edges of the host clock, 0 if none
   task automatic period(input logic [7:0] exp);
      int k;
      int first;
      logic p;
      first = -1;
      n = 0;
      p = mclk;
      for (k = 0; k < 100; k++) begin
         @(posedge clk) #1;
         if (!p && mclk && n == 0) begin
            if (first >= 0) n = k - first;
            first = k;
         end
         p = mclk;
      end
      chk(8'(n), exp);
   endtask

   task automatic pdc(input logic s, input logic d, input logic e);
      ss_n = s;
      sdo_drv = d;
      settle(2);
      chk({7'h0, pd}, {7'h0, e});
   endtask

   task automatic ramp();
      n = 0;
      tx_on = 1'b1;
      while (done !== 1'b1 && n < 1000) begin
         @(posedge clk) #1;
         n++;
         if (n == 100) chk({7'h0, slow}, 8'h01);
      end
      chk({7'h0, done}, 8'h01);
      tx_on = 1'b0;
      settle(2);
   endtask

   initial begin
      #250000;
      n_mismatch++;
      results();
   end

   initial begin
      rst = 1'b1;
      por = 1'b1;
      xrun = 1'b1;
      lfclk = 1'b0;
      ss_n = 1'b1;
      sdo_drv = 1'b0;
      tx_on = 1'b0;
      settle(3);
      rst = 1'b0;
      por = 1'b0;
      settle(1);
      rdchk(ADDR_CFG_A, 8'h08);
      rdchk(ADDR_CFG_B, 8'h00);
      chk({7'h0, xsel}, 8'h01);
      chk({3'h0, se, oa, ia, ob, ib}, 8'h0f);
      cfg(ADDR_CFG_A, 8'h88);
      chk({3'h0, se, oa, ia, ob, ib}, 8'h1c);
      cfg(ADDR_CFG_A, 8'hc8);
      chk({3'h0, se, oa, ia, ob, ib}, 8'h13);
      cfg(ADDR_CFG_A, 8'h48);
      chk({3'h0, se, oa, ia, ob, ib}, 8'h0f);
      cfg(ADDR_CFG_A, 8'h38);
      chk({1'b0, rxl}, 8'h50);
      chk({1'b0, txl}, 8'h10);
      cfg(ADDR_CFG_A, 8'h08);
      chk({1'b0, rxl}, 8'h40);
      chk({1'b0, txl}, 8'h20);
      for (int i = 0; i < 4; i++) begin
         cfg(ADDR_CFG_A, 8'(2 * i));
         chk({7'h0, xsel}, 8'h00);
         period(8'(i == 3 ? 0 : 8 >> i));
      end
      chk({7'h0, mclk}, 8'h00);
      // Oscillator stopped: low-frequency clock takes over
      xrun = 1'b0;
      cfg(ADDR_CFG_A, 8'h00);
      lfclk = 1'b1;
      settle(3);
      chk({7'h0, mclk}, 8'h01);
      lfclk = 1'b0;
      settle(3);
      chk({7'h0, mclk}, 8'h00);
      lfclk = 1'b1;
      cfg(ADDR_CFG_A, 8'h01);
      settle(1);
      chk({7'h0, mclk}, 8'h00);
      cfg(ADDR_CFG_A, 8'h06);
      settle(1);
      chk({7'h0, mclk}, 8'h00);
      xrun = 1'b1;
      cfg(ADDR_CFG_B, 8'hff);
      rdchk(ADDR_CFG_B, 8'hdd);
      chk({5'h0, sup, vreg, hd}, 8'h07);
      cfg(ADDR_CFG_B, 8'h84);
      chk({5'h0, sup, vreg, hd}, 8'h05);
      cfg(ADDR_CFG_B, 8'h10);
      pdc(1'b0, 1'b0, 1'b1);
      pdc(1'b0, 1'b1, 1'b0);
      pdc(1'b1, 1'b0, 1'b0);
      cfg(ADDR_CFG_B, 8'h08);
      pdc(1'b1, 1'b1, 1'b1);
      pdc(1'b0, 1'b0, 1'b0);
      host.wr(8'h02, 8'hff);
      rdchk(8'h02, 8'h00);
      rdchk(ADDR_CFG_B, 8'h08);
      cfg(ADDR_CFG_B, 8'h01);
      ramp();
      chk(8'(n >= 400), 8'h01);
      cfg(ADDR_CFG_B, 8'h00);
      ramp();
      chk(8'(n < 4), 8'h01);
      // Soft reset keeps contents, power-up reset restores defaults
      cfg(ADDR_CFG_A, 8'h35);
      rst = 1'b1;
      settle(1);
      rst = 1'b0;
      settle(1);
      rdchk(ADDR_CFG_A, 8'h35);
      chk({1'b0, rxl}, 8'h50);
      por = 1'b1;
      settle(1);
      por = 1'b0;
      settle(1);
      rdchk(ADDR_CFG_A, 8'h08);
      results();
   end
endmodule
`default_nettype wire
